// ---- shared/bridge_status_defines.svh ----
// Offsets, field positions, reset values and counts of the bridge status block.
`ifndef BRIDGE_STATUS_DEFINES_SVH
`define BRIDGE_STATUS_DEFINES_SVH
`define ADDR_MEMORY_STATUS 8'h64
`define ADDR_LINK_CONTROL 8'h68
`define ADDR_LINK_STATUS 8'h6C
`define ADDR_ERROR_MASK 8'h70
`define ADDR_DRAM_TIMING 8'h78
`define ADDR_MAPPING_REG 8'h80
`define ADDR_OFFSET_REG 8'h84
`define MS_THR_BIT 16
`define MS_RQD_MSB 15
`define MS_RQD_LSB 11
`define MS_WQD_MSB 10
`define MS_WQD_LSB 6
`define MS_COPY_BIT 5
`define MS_FR_MSB 4
`define MS_FR_LSB 2
`define MS_SFO_BIT 1
`define MS_WP_BIT 0
`define LC_HIGH_MSB 3
`define LC_HIGH_LSB 0
`define PERIOD_RST 6'h0D
`define TRANS_RST 4'h3
`define LOW_RST 4'hB
`define HIGH_RST 4'hD
`define OFFSET_INIT 6'h02
`define MAPPING_INIT 6'h03
`define MAPPING_RST 6'h00
`define OFFSET_RST 6'h00
`define ERROR_MASK_RST 23'h7FEFFF
`define DRT_RST 32'h00000000
`define DRT_WMASK 32'h7FFCFFFF
`define WIN_LAST 4'hF
`define HOLD_MIN_WRITES 4'h4
`define FATAL_MSB 22
`define FATAL_LSB 21
`define ERR_BITS 23
`define LANES 21
`endif

// ---- shared/bridge_status_pkg.sv ----
// Types shared by the bridge status and link control block.
`default_nettype none
package bridge_status_pkg;
	typedef struct packed {
		logic [5:0] period;
		logic [3:0] min_trans;
		logic [3:0] low;
		logic [3:0] high;
	} link_ctrl_s;
	typedef struct packed {
		logic active;
		logic done;
		logic [2:0] rank;
	} sparing_s;
	typedef enum logic [0:0] {
		FLOW_GO = 1'b0,
		FLOW_STOP = 1'b1
	} flow_e;
	typedef logic [7:0][3:0] rank_counts_t;
endpackage
`default_nettype wire

// ---- rtl/memory_bridge_status_link_control.sv ----
// Status, link control and error mask registers of the memory bridge.
`timescale 1ns/10ps
`default_nettype none
`include "bridge_status_defines.svh"
// Operation
// - Threshold flag set on count match, interrupts
// - Report read queue occupancy
// - Report write queue occupancy, zero clears posted
// - Copy flag set at single rank threshold
// - Capture failed rank when copy starts
// - Fail-over flag, interrupt, cleared by sparing disable
// - Writes posted follows nonzero write queue
// - Insert idles after quiet window run
// - Idles follow detection by two windows
// - Lane trained needs programmed transition count
// - Offset write accepted only with init, mapped
// - Mapping write accepted only with init
// - Release flow control at low watermark
// - Hold reads until enough writes issued
// - Stop flow at or above high watermark
// - Link ready reported only when usable
// - Mask bit one disables its error
// - Masked errors reach no status or signal
// - Top two mask bits are fatal errors
// - Masks reset masked except rejected write
// - Fail-over needs exactly one rank at threshold
module memory_bridge_status_link_control (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic [4:0] read_queue_depth_i,
	input wire logic [4:0] write_queue_depth_i,
	input wire logic write_issued_i,
	input wire logic sparing_enable_i,
	input wire logic [3:0] spare_error_threshold_i,
	input wire bridge_status_pkg::rank_counts_t uncorrectable_count_i,
	input wire bridge_status_pkg::rank_counts_t correctable_count_i,
	input wire logic spare_copy_done_i,
	input wire logic link_ready_i,
	input wire logic [20:0] link_out_i,
	input wire logic [22:0] error_event_i,
	output logic [22:0] error_enabled_o,
	output logic fatal_error_o,
	output logic stop_flow_o,
	output logic hold_reads_o,
	output logic insert_idle_o,
	output logic inband_interrupt_o,
	output logic sparing_copy_active_o,
	output logic [2:0] failed_rank_o,
	output logic [31:0] dram_timing_o,
	output logic [5:0] mapping_o,
	output logic [5:0] offset_o
);

	// ************************************************************
	// Register bus decode and software registers
	// ************************************************************
	bridge_status_pkg::link_ctrl_s ctrl_r;
	bridge_status_pkg::sparing_s spare_r;
	bridge_status_pkg::flow_e flow_r;
	bridge_status_pkg::flow_e flow_nxt;
	logic [22:0] mask_r;
	logic [31:0] drt_r;
	logic [5:0] mapping_r;
	logic [5:0] offset_r;
	logic [4:0] rqd_r;
	logic [4:0] wqd_r;
	logic thr_r;
	logic link_ready_r;
	logic irq_r;
	logic [31:0] rdata_r;
	logic [22:0] err_en_r;
	logic fatal_r;

	wire hit_ms = addr_i == `ADDR_MEMORY_STATUS;
	wire hit_lc = addr_i == `ADDR_LINK_CONTROL;
	wire hit_ls = addr_i == `ADDR_LINK_STATUS;
	wire hit_em = addr_i == `ADDR_ERROR_MASK;
	wire hit_dt = addr_i == `ADDR_DRAM_TIMING;
	wire hit_mp = addr_i == `ADDR_MAPPING_REG;
	wire hit_of = addr_i == `ADDR_OFFSET_REG;
	wire wr_lc = wr_i && hit_lc;
	wire wr_em = wr_i && hit_em;
	wire wr_dt = wr_i && hit_dt;
	// A mapping or offset write with any other value is dropped silently.
	wire wr_mp_ok = wr_i && hit_mp && (wdata_i[5:0] == `MAPPING_INIT);
	wire map_ready = mapping_r == `MAPPING_INIT;
	wire wr_of_ok = wr_i && hit_of && map_ready &&
		(wdata_i[5:0] == `OFFSET_INIT);
	wire posted = wqd_r != 5'h00;

	wire [31:0] ms_word = {15'h0000, thr_r, rqd_r, wqd_r, spare_r.active,
		spare_r.rank, spare_r.done, posted};
	wire [31:0] lc_word = {ctrl_r.period, ctrl_r.min_trans, `OFFSET_INIT,
		2'b00, `MAPPING_INIT, ctrl_r.low, ctrl_r.high};
	wire [31:0] ls_word = {31'h00000000, link_ready_r};
	wire [31:0] em_word = {9'h000, mask_r};
	wire [31:0] mp_word = {26'h0000000, mapping_r};
	wire [31:0] of_word = {26'h0000000, offset_r};
	// Unmapped addresses read as zero.
	wire [31:0] rd_mux = hit_ms ? ms_word :
		hit_lc ? lc_word :
		hit_ls ? ls_word :
		hit_em ? em_word :
		hit_dt ? drt_r :
		hit_mp ? mp_word :
		hit_of ? of_word : 32'h00000000;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_r <= 32'h00000000;
		end else begin
			rdata_r <= rd_i ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_r <= {`PERIOD_RST, `TRANS_RST, `LOW_RST, `HIGH_RST};
			mask_r <= `ERROR_MASK_RST;
			drt_r <= `DRT_RST;
			mapping_r <= `MAPPING_RST;
			offset_r <= `OFFSET_RST;
		end else begin
			if (wr_lc) begin
				ctrl_r <= {wdata_i[31:22], wdata_i[7:0]};
			end
			if (wr_em) begin
				mask_r <= wdata_i[22:0];
			end
			if (wr_dt) begin
				drt_r <= wdata_i & `DRT_WMASK;
			end
			if (wr_mp_ok) begin
				mapping_r <= wdata_i[5:0];
			end
			if (wr_of_ok) begin
				offset_r <= wdata_i[5:0];
			end
		end
	end

	// ************************************************************
	// Queue depth, link ready and error gating
	// ************************************************************
	wire [22:0] err_gated = error_event_i & ~mask_r;
	wire fatal_now = |err_gated[`FATAL_MSB:`FATAL_LSB];

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rqd_r <= 5'h00;
			wqd_r <= 5'h00;
			link_ready_r <= 1'b0;
			err_en_r <= 23'h000000;
			fatal_r <= 1'b0;
		end else begin
			rqd_r <= read_queue_depth_i;
			wqd_r <= write_queue_depth_i;
			link_ready_r <= link_ready_i;
			err_en_r <= err_gated;
			fatal_r <= fatal_now;
		end
	end

	// ************************************************************
	// Rank threshold and sparing
	// ************************************************************
	logic [7:0] at_thr;
	logic [2:0] hit_rank;
	genvar gr;
	generate
		for (gr = 0; gr < 8; gr++) begin : g_rank
			assign at_thr[gr] =
				(uncorrectable_count_i[gr] == spare_error_threshold_i) ||
				(correctable_count_i[gr] == spare_error_threshold_i);
		end
	endgenerate

	always_comb begin
		hit_rank = 3'h0;
		for (int i = 0; i < 8; i++) begin
			if (at_thr[i]) begin
				hit_rank = 3'(i);
			end
		end
	end

	// A zero threshold would match every idle counter, so it arms nothing.
	wire thr_armed = spare_error_threshold_i != 4'h0;
	wire thr_now = thr_armed && (|at_thr);
	wire one_rank = thr_armed && $onehot(at_thr);
	wire copy_start = sparing_enable_i && one_rank && !spare_r.active &&
		!spare_r.done;
	wire sfo_set = spare_r.active && spare_copy_done_i;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			spare_r <= {1'b0, 1'b0, 3'h0};
			thr_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			thr_r <= thr_now;
			irq_r <= (thr_now && !thr_r) || sfo_set;
			if (copy_start) begin
				spare_r.active <= 1'b1;
				spare_r.rank <= hit_rank;
			end else if (sfo_set || !sparing_enable_i) begin
				spare_r.active <= 1'b0;
			end
			// Set wins over the sparing-disable clear.
			if (sfo_set) begin
				spare_r.done <= 1'b1;
			end else if (!sparing_enable_i) begin
				spare_r.done <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Link idle training
	// ************************************************************
	logic [3:0] win_bit_r;
	logic [20:0] prev_r;
	logic [20:0] lane_due;
	logic [1:0] pend_r;
	logic ins_r;
	wire win_end = win_bit_r == `WIN_LAST;
	wire detect = win_end && (|lane_due);
	genvar gl;
	generate
		for (gl = 0; gl < `LANES; gl++) begin : g_lane
			logic [4:0] trans_r;
			logic [5:0] quiet_r;
			wire edge_now = link_out_i[gl] ^ prev_r[gl];
			wire [4:0] trans_now = 5'(trans_r + {4'h0, edge_now});
			wire bad = trans_now < {1'b0, ctrl_r.min_trans};
			wire [5:0] quiet_now = bad ? 6'(quiet_r + 6'h01) : 6'h00;
			assign lane_due[gl] = bad && (ctrl_r.period != 6'h00) &&
				(quiet_now >= ctrl_r.period);
			always_ff @(posedge clk_sys_i or negedge rstn_i) begin
				if (!rstn_i) begin
					trans_r <= 5'h00;
					quiet_r <= 6'h00;
				end else if (win_end) begin
					trans_r <= 5'h00;
					quiet_r <= detect ? 6'h00 : quiet_now;
				end else begin
					trans_r <= trans_now;
				end
			end
		end
	endgenerate

	// Two window ends pass between detection and the idle request.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			win_bit_r <= 4'h0;
			prev_r <= 21'h000000;
			pend_r <= 2'b00;
			ins_r <= 1'b0;
		end else begin
			win_bit_r <= 4'(win_bit_r + 4'h1);
			prev_r <= link_out_i;
			if (win_end) begin
				pend_r <= {pend_r[0], detect};
			end
			ins_r <= win_end && pend_r[1];
		end
	end

	// ************************************************************
	// Write post queue flow control
	// ************************************************************
	logic hold_r;
	logic [3:0] issued_r;
	wire at_high = write_queue_depth_i >= {1'b0, ctrl_r.high};
	wire at_low = write_queue_depth_i <= {1'b0, ctrl_r.low};
	wire [3:0] need = (ctrl_r.high < `HOLD_MIN_WRITES) ?
		ctrl_r.high : `HOLD_MIN_WRITES;
	wire [3:0] issued_now = 4'(issued_r + {3'h0, write_issued_i});

	always_comb begin
		flow_nxt = flow_r;
		case (flow_r)
			bridge_status_pkg::FLOW_GO: begin
				if (at_high) begin
					flow_nxt = bridge_status_pkg::FLOW_STOP;
				end
			end
			bridge_status_pkg::FLOW_STOP: begin
				if (at_low) begin
					flow_nxt = bridge_status_pkg::FLOW_GO;
				end
			end
			default: begin
				flow_nxt = bridge_status_pkg::FLOW_GO;
			end
		endcase
	end

	wire hold_start = (flow_r == bridge_status_pkg::FLOW_GO) && at_high &&
		(need != 4'h0);

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flow_r <= bridge_status_pkg::FLOW_GO;
			hold_r <= 1'b0;
			issued_r <= 4'h0;
		end else begin
			flow_r <= flow_nxt;
			if (hold_start) begin
				hold_r <= 1'b1;
				issued_r <= 4'h0;
			end else if (hold_r) begin
				issued_r <= issued_now;
				if (issued_now >= need) begin
					hold_r <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign rdata_o = rdata_r;
	assign error_enabled_o = err_en_r;
	assign fatal_error_o = fatal_r;
	assign stop_flow_o = flow_r == bridge_status_pkg::FLOW_STOP;
	assign hold_reads_o = hold_r;
	assign insert_idle_o = ins_r;
	assign inband_interrupt_o = irq_r;
	assign sparing_copy_active_o = spare_r.active;
	assign failed_rank_o = spare_r.rank;
	assign dram_timing_o = drt_r;
	assign mapping_o = mapping_r;
	assign offset_o = offset_r;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);

	property p_thr_irq;
		thr_now && !thr_r |=> thr_r && inband_interrupt_o;
	endproperty
	a_thr_irq: assert property (p_thr_irq) else $error("threshold lost");

	property p_rqd_read;
		rd_i && hit_ms |=> rdata_o[`MS_RQD_MSB:`MS_RQD_LSB] == $past(rqd_r);
	endproperty
	a_rqd_read: assert property (p_rqd_read) else $error("rqd bad");

	property p_wp_zero;
		(rd_i && hit_ms ##1 rdata_o[`MS_WQD_MSB:`MS_WQD_LSB] == 5'h00) |->
			!rdata_o[`MS_WP_BIT];
	endproperty
	a_wp_zero: assert property (p_wp_zero) else $error("wp with empty");

	property p_wp_set;
		(rd_i && hit_ms ##1 rdata_o[`MS_WQD_MSB:`MS_WQD_LSB] != 5'h00) |->
			rdata_o[`MS_WP_BIT];
	endproperty
	a_wp_set: assert property (p_wp_set) else $error("wp missing");

	property p_copy_start;
		copy_start |=> sparing_copy_active_o &&
			failed_rank_o == $past(hit_rank);
	endproperty
	a_copy_start: assert property (p_copy_start) else $error("copy");

	property p_rank_hold;
		sparing_copy_active_o && $past(sparing_copy_active_o) |->
			$stable(failed_rank_o);
	endproperty
	a_rank_hold: assert property (p_rank_hold) else $error("rank");

	property p_sfo;
		sfo_set |=> spare_r.done && !spare_r.active && inband_interrupt_o;
	endproperty
	a_sfo: assert property (p_sfo) else $error("fail-over");

	property p_idle_latency;
		detect |-> ##33 insert_idle_o;
	endproperty
	a_idle_latency: assert property (p_idle_latency) else $error("idle");

	property p_flow_stop;
		!stop_flow_o && at_high |=> stop_flow_o;
	endproperty
	a_flow_stop: assert property (p_flow_stop) else $error("no stop");

	property p_flow_go;
		stop_flow_o && at_low |=> !stop_flow_o;
	endproperty
	a_flow_go: assert property (p_flow_go) else $error("no release");

	property p_hold;
		hold_start |=> hold_reads_o;
	endproperty
	a_hold: assert property (p_hold) else $error("no read hold");

	property p_map_refuse;
		wr_i && hit_mp && wdata_i[5:0] != `MAPPING_INIT |=> $stable(mapping_o);
	endproperty
	a_map_refuse: assert property (p_map_refuse) else $error("map");

	property p_off_refuse;
		wr_i && hit_of && !map_ready |=> $stable(offset_o);
	endproperty
	a_off_refuse: assert property (p_off_refuse) else $error("offset");

	property p_mask;
		1'b1 |=> (error_enabled_o & $past(mask_r)) == 23'h000000;
	endproperty
	a_mask: assert property (p_mask) else $error("masked error");

	property p_fatal;
		error_event_i[`FATAL_MSB] && !mask_r[`FATAL_MSB] |=> fatal_error_o;
	endproperty
	a_fatal: assert property (p_fatal) else $error("fatal lost");

	property p_ready;
		rd_i && hit_ls |=> rdata_o == {31'h00000000, $past(link_ready_r)};
	endproperty
	a_ready: assert property (p_ready) else $error("link ready");

	c_copy: cover property (copy_start ##[1:50] sfo_set);
	c_idle: cover property (insert_idle_o);
	c_flow: cover property (stop_flow_o ##[1:50] !stop_flow_o);
	c_hold: cover property (hold_reads_o ##1 !hold_reads_o);

endmodule
`default_nettype wire

// ---- verification/link_host_model.sv ----
// Host side of the memory link: posts writes into the bridge write queue.
`timescale 1ns/10ps
`default_nettype none
module link_host_model (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic post_en_i,
	input wire logic link_ready_i,
	input wire logic stop_flow_i,
	input wire logic write_issued_i,
	output logic [4:0] depth_o
);
	// ****************************************
	// Queue occupancy seen from the host
	// ****************************************
	// A real host keeps posting unless told to stop, so the bench can only
	// see an overshoot if the flow control is late.
	wire logic post = post_en_i & link_ready_i & ~stop_flow_i &
		(depth_o != 5'h1F);
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			depth_o <= 5'h00;
		end else begin
			depth_o <= depth_o + {4'h0, post} - {4'h0, write_issued_i};
		end
	end
endmodule
`default_nettype wire

// ---- verification/memory_bridge_status_link_control_test.sv ----
// Self-checking bench of the bridge status and link control block.
`timescale 1ns/10ps
`default_nettype none
`include "bridge_status_defines.svh"
module memory_bridge_status_link_control_test;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic [4:0] read_queue_depth = 5'h00;
	logic [4:0] write_queue_depth;
	logic issued = 1'b0;
	logic spare_en = 1'b0;
	logic [3:0] thr = 4'h0;
	bridge_status_pkg::rank_counts_t ucnt = 32'h0;
	bridge_status_pkg::rank_counts_t ccnt = 32'h0;
	logic copy_done = 1'b0;
	logic link_rdy = 1'b0;
	logic [20:0] lanes = 21'h0;
	logic toggle = 1'b1;
	logic post_en = 1'b0;
	logic [22:0] err_ev = 23'h0;
	logic [22:0] err_en;
	logic fatal, stop, hold, idle, irq, active;
	logic [2:0] rank;
	logic [31:0] dram_t;
	logic [5:0] map;
	logic [5:0] offs;
	logic [31:0] rv;
	int error_cnt = 0;
	int total_checks = 0;
	int irq_cnt = 0;
	int idle_cnt = 0;
	time idle_t = 0;
	time idle_gap = 0;

	memory_bridge_status_link_control dut_u (.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .read_queue_depth_i(read_queue_depth),
		.write_queue_depth_i(write_queue_depth), .write_issued_i(issued),
		.sparing_enable_i(spare_en), .spare_error_threshold_i(thr),
		.uncorrectable_count_i(ucnt), .correctable_count_i(ccnt),
		.spare_copy_done_i(copy_done), .link_ready_i(link_rdy),
		.link_out_i(lanes), .error_event_i(err_ev), .error_enabled_o(err_en),
		.fatal_error_o(fatal), .stop_flow_o(stop), .hold_reads_o(hold),
		.insert_idle_o(idle), .inband_interrupt_o(irq),
		.sparing_copy_active_o(active), .failed_rank_o(rank),
		.dram_timing_o(dram_t), .mapping_o(map), .offset_o(offs));
	link_host_model host_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.post_en_i(post_en), .link_ready_i(link_rdy), .stop_flow_i(stop),
		.write_issued_i(issued), .depth_o(write_queue_depth));

	// ****************************************
	// Clock, lane activity and monitors
	// ****************************************
	always #20 clk_sys_i = ~clk_sys_i;
	// Toggling lanes give sixteen transitions per window, one above the largest count of fifteen.
	always @(posedge clk_sys_i) begin
		if (toggle) begin
			lanes <= ~lanes;
		end
	end
	always @(posedge clk_sys_i) begin
		if (irq === 1'b1) begin
			irq_cnt++;
		end
		if (idle === 1'b1) begin
			idle_cnt++;
			idle_gap = $time - idle_t;
			idle_t = $time;
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		rv = rdata_o;
	endtask
	task wrchk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		wr(a, d);
		rd(a);
		check(rv, e);
	endtask
	task drain;
		@(posedge clk_sys_i);
		issued <= 1'b1;
		@(posedge clk_sys_i);
		issued <= 1'b0;
	endtask
	task ev_chk(input logic [22:0] m, input logic fat);
		wr(`ADDR_ERROR_MASK, {9'h0, m});
		@(posedge clk_sys_i);
		err_ev <= 23'h7FFFFF;
		@(posedge clk_sys_i);
		err_ev <= 23'h0;
		#1;
		check({9'h0, err_en}, {9'h0, ~m});
		check({31'h0, fatal}, {31'h0, fat});
	endtask
	task wrap_up;
		$display("Checks %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		rd(`ADDR_LINK_CONTROL);
		check(rv, 32'h34C203BD);
		rd(`ADDR_ERROR_MASK);
		check(rv, 32'h007FEFFF);
		rd(8'h74);
		check(rv, 32'h0);
		rd(`ADDR_LINK_STATUS);
		check(rv, 32'h0);
		@(posedge clk_sys_i);
		link_rdy <= 1'b1;
		cyc(2);
		rd(`ADDR_LINK_STATUS);
		check(rv, 32'h1);
		$display("Reset values done");
	endtask
	task t_regs;
		wrchk(`ADDR_LINK_CONTROL, 32'hFFFFFFFF, 32'hFFC203FF);
		wrchk(`ADDR_DRAM_TIMING, 32'hFFFFFFFF, 32'h7FFCFFFF);
		check(dram_t, 32'h7FFCFFFF);
		wrchk(`ADDR_ERROR_MASK, 32'hFFFFFFFF, 32'h007FFFFF);
		wrchk(`ADDR_OFFSET_REG, 32'h2, 32'h0);
		wrchk(`ADDR_MAPPING_REG, 32'h5, 32'h0);
		wrchk(`ADDR_MAPPING_REG, 32'h3, 32'h3);
		wrchk(`ADDR_OFFSET_REG, 32'h7, 32'h0);
		wrchk(`ADDR_OFFSET_REG, 32'h2, 32'h2);
		check({20'h0, map, offs}, 32'hC2);
		$display("Register access done");
	endtask
	task t_err;
		ev_chk(23'h000000, 1'b1);
		ev_chk(23'h7FFFFE, 1'b0);
		ev_chk(23'h5FFFFF, 1'b1);
		ev_chk(23'h3FFFFF, 1'b1);
		$display("Error mask done");
	endtask
	task t_flow;
		int i;
		wr(`ADDR_LINK_CONTROL, 32'h34C20326);
		@(posedge clk_sys_i);
		read_queue_depth <= 5'h15;
		post_en <= 1'b1;
		for (i = 0; i < 40 && stop !== 1'b1; i++) begin
			cyc(1);
		end
		@(posedge clk_sys_i);
		post_en <= 1'b0;
		cyc(2);
		check(32'(write_queue_depth >= 5'h06 && stop === 1'b1), 32'h1);
		check({31'h0, hold}, 32'h1);
		rd(`ADDR_MEMORY_STATUS);
		check(rv, {16'h0, 5'h15, write_queue_depth, 5'h0, 1'b1});
		repeat (3) drain();
		cyc(2);
		check({31'h0, hold}, 32'h1);
		drain();
		cyc(2);
		check({31'h0, hold}, 32'h0);
		while (write_queue_depth > 5'h02) begin
			check({31'h0, stop}, 32'h1);
			drain();
			cyc(1);
		end
		cyc(2);
		check({31'h0, stop}, 32'h0);
		@(posedge clk_sys_i);
		post_en <= 1'b1;
		@(posedge clk_sys_i);
		post_en <= 1'b0;
		cyc(2);
		check({31'h0, stop}, 32'h0);
		// The depth settles one edge after each pulse, so look only then.
		while (write_queue_depth != 5'h00) begin
			drain();
			cyc(1);
		end
		cyc(3);
		rd(`ADDR_MEMORY_STATUS);
		check(rv & 32'h000007C1, 32'h0);
		$display("Flow control done");
	endtask
	task t_spare;
		@(posedge clk_sys_i);
		spare_en <= 1'b1;
		thr <= 4'h4;
		ucnt[3] <= 4'h4;
		cyc(1);
		check({28'h0, active, rank}, 32'hB);
		cyc(3);
		rd(`ADDR_MEMORY_STATUS);
		check(rv & 32'h0001003F, 32'h0001002C);
		check(32'(irq_cnt), 32'h1);
		@(posedge clk_sys_i);
		copy_done <= 1'b1;
		@(posedge clk_sys_i);
		copy_done <= 1'b0;
		cyc(2);
		rd(`ADDR_MEMORY_STATUS);
		check(rv & 32'h3F, 32'hE);
		check(32'(irq_cnt), 32'h2);
		@(posedge clk_sys_i);
		ucnt <= 32'h0;
		spare_en <= 1'b0;
		cyc(3);
		rd(`ADDR_MEMORY_STATUS);
		check(rv & 32'h00010022, 32'h0);
		@(posedge clk_sys_i);
		spare_en <= 1'b1;
		ucnt[1] <= 4'h4;
		ccnt[5] <= 4'h4;
		cyc(3);
		check({31'h0, active}, 32'h0);
		$display("Sparing done");
	endtask
	task t_idle;
		int i;
		check(32'(idle_cnt), 32'h0);
		wr(`ADDR_LINK_CONTROL, 32'h34020326);
		@(posedge clk_sys_i);
		toggle <= 1'b0;
		// A zero transition count keeps quiet lanes trained.
		cyc(300);
		check(32'(idle_cnt), 32'h0);
		wr(`ADDR_LINK_CONTROL, 32'h34C20326);
		for (i = 0; i < 1000 && idle_cnt < 2; i++) begin
			cyc(1);
		end
		check(32'(idle_cnt), 32'h2);
		// Steady state spacing is the period in windows of sixteen cycles.
		check(32'(idle_gap == 13 * 16 * 40), 32'h1);
		check(32'(idle_gap <= 15 * 16 * 40), 32'h1);
		$display("Idle insertion done");
	endtask

	initial begin
		repeat (3) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		t_reset();
		t_regs();
		t_err();
		t_flow();
		t_spare();
		t_idle();
		wrap_up();
	end
	initial begin
		#(40 * 20000);
		error_cnt++;
		wrap_up();
	end
endmodule
`default_nettype wire
